// file: rtl/rx_filter_pkg.sv
/*
   Constants, register map and frame descriptor type for the receive
   checksum filter and frame status block.
   Assumes a host on AXI4-Lite with 32-bit data and a receive datapath
   on the same clock that reports each finished frame as one descriptor.
*/
// Notes on behaviour
// - Fragment-pass bit set lets fragmented UDP frames skip the checksum check.
// - Fragment-pass bit clear applies UDP checksum checks regardless of fragmentation.
// - Zero-checksum bit set passes non-Lite UDP frames with zero checksum, else drops them.
// - UDP-Lite enable set verifies Lite checksums on receive, generates on transmit.
// - UDP-Lite enable clear passes Lite frames and skips transmit Lite checksum.
// - ICMP check enable discards non-fragment ICMP frames with a bad checksum.
// - Source filter enable drops frames whose source equals the station address.
// - Free transmit memory is reported in bytes in a 13-bit read-only field.
// - Frame-valid bit set only when a finished frame and its status wait.
// - Status flags bad ICMP, IP header, TCP and UDP checksums in bits 13-10.
// - Status marks broadcast, multicast (broadcast too) and unicast in bits 7-5.
// - Status bit 4 reports a media interface symbol error in the frame.
// - Frame-type bit set when length field exceeds 1500, meaningless for runts.
// - Too-long bit set above 2000 bytes; such frames kept only with bad-pass.
// - Too-long flags and, without bad-pass, drops the frame; frames are never truncated for it.
// - Status is readable once per frame the frame counter reports.
package rx_filter_pkg;

   // Printed register indices; byte address is four times the index
   localparam logic [7:0] IDX_CHECKSUM_CONTROL = 8'h76;
   localparam logic [7:0] IDX_TRANSMIT_FREE = 8'h78;
   localparam logic [7:0] IDX_FRAME_STATUS = 8'h7c;
   localparam logic [7:0] IDX_STATION_LOW = 8'h40;
   localparam logic [7:0] IDX_STATION_MID = 8'h41;
   localparam logic [7:0] IDX_STATION_HIGH = 8'h42;
   localparam logic [7:0] IDX_FILTER_OPTIONS = 8'h43;
   localparam logic [7:0] IDX_FRAME_RELEASE = 8'h44;
   localparam logic [7:0] IDX_FRAME_COUNT = 8'h45;
   localparam logic [7:0] IDX_INT_STATUS = 8'h46;
   localparam logic [7:0] IDX_INT_MASK = 8'h47;

   // Checksum control fields
   localparam int FRAGMENT_PASS_BIT = 4;
   localparam int ZERO_PASS_BIT = 3;
   localparam int LITE_ENABLE_BIT = 2;
   localparam int ICMP_CHECK_BIT = 1;
   localparam int SOURCE_FILTER_BIT = 0;
   localparam logic [4:0] CHECKSUM_CONTROL_RESET = 5'h04;

   // Filter options fields
   localparam int BAD_PASS_BIT = 0;
   localparam int UDP_CHECK_BIT = 1;
   localparam logic [1:0] FILTER_OPTIONS_RESET = 2'h0;

   // Frame status fields
   localparam int VALID_BIT = 15;
   localparam int ICMP_BAD_BIT = 13;
   localparam int IP_BAD_BIT = 12;
   localparam int TCP_BAD_BIT = 11;
   localparam int UDP_BAD_BIT = 10;
   localparam int BROADCAST_BIT = 7;
   localparam int MULTICAST_BIT = 6;
   localparam int UNICAST_BIT = 5;
   localparam int SYMBOL_ERROR_BIT = 4;
   localparam int FRAME_TYPE_BIT = 3;
   localparam int TOO_LONG_BIT = 2;

   // Interrupt events
   localparam int EVENT_RECEIVED = 0;
   localparam int EVENT_DROPPED = 1;
   localparam int EVENT_OVERFLOW = 2;
   localparam int EVENT_COUNT = 3;

   // Length limits in bytes
   localparam logic [15:0] ETHERTYPE_MIN_LENGTH = 16'h05dc;
   localparam logic [15:0] TOO_LONG_LENGTH = 16'h07d0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One finished frame as classified by the receive datapath
   typedef struct packed {
      logic isUdp;
      logic isUdpLite;
      logic isIcmp;
      logic isFragment;
      logic udpChecksumZero;
      logic icmpChecksumBad;
      logic ipHeaderChecksumBad;
      logic tcpChecksumBad;
      logic udpChecksumBad;
      logic symbolError;
      logic runt;
      logic [47:0] sourceAddress;
      logic [47:0] destAddress;
      logic [15:0] typeLength;
      logic [15:0] frameLength;
   } frame_info_type;

endpackage : rx_filter_pkg

// file: rtl/rx_checksum_filter_status.sv
/*
   Receive checksum filter, transmit free-space report and per-frame
   receive status queue, with an AXI4-Lite register slave and interrupt.
   Assumes frame descriptors and the free-byte count come from logic on
   ref_clk, and that the host releases each frame after reading status.
*/
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
module rx_checksum_filter_status #(
   parameter int STATUS_DEPTH = 8,
   parameter int COUNT_WIDTH = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // AXI4-Lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Receive datapath
   input wire logic frameEnd,
   input wire rx_filter_pkg::frame_info_type frameInfo,
   output logic frameAccept,
   output logic frameDrop,
   // Transmit side
   input wire logic [12:0] transmitFreeBytes,
   output logic txUdpLiteChecksumGen,
   // Interrupt
   output logic irq
);
   import rx_filter_pkg::*;

   // Merge a write into a 16-bit register by byte strobes
   function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [15:0] result;
      result = old;
      if (strb[0]) begin
         result[7:0] = data[7:0];
      end
      if (strb[1]) begin
         result[15:8] = data[15:8];
      end
      return result;
   endfunction : mergeBytes

   // Byte address of a register index
   function automatic logic [11:0] byteAddr(input logic [7:0] index);
      return {2'h0, index, 2'h0};
   endfunction : byteAddr

   logic [4:0] checksumControl;
   logic [1:0] filterOptions;
   logic [47:0] stationAddress;
   logic [EVENT_COUNT-1:0] intStatus;
   logic [EVENT_COUNT-1:0] intMask;
   logic [12:0] transmitFree;
   logic [15:0] statusMem [STATUS_DEPTH];
   logic [COUNT_WIDTH-1:0] readPtr;
   logic [COUNT_WIDTH-1:0] writePtr;
   logic [COUNT_WIDTH-1:0] frameCount;
   logic awFull;
   logic wFull;
   logic [11:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;

   // Control fields
   wire fragmentPass = checksumControl[FRAGMENT_PASS_BIT];
   wire zeroPass = checksumControl[ZERO_PASS_BIT];
   wire liteEnable = checksumControl[LITE_ENABLE_BIT];
   wire icmpCheck = checksumControl[ICMP_CHECK_BIT];
   wire sourceFilter = checksumControl[SOURCE_FILTER_BIT];
   wire badPass = filterOptions[BAD_PASS_BIT];
   wire udpCheck = filterOptions[UDP_CHECK_BIT];

   // UDP check: Lite frames follow the Lite enable, fragments may be waived
   wire liteChecked = frameInfo.isUdpLite & liteEnable;
   wire plainChecked = ~frameInfo.isUdpLite & udpCheck;
   wire fragmentWaived = frameInfo.isFragment & fragmentPass;
   wire udpDrop = frameInfo.isUdp & frameInfo.udpChecksumBad & ~frameInfo.udpChecksumZero
                  & (liteChecked | plainChecked) & ~fragmentWaived;
   // Zero checksum means no checksum was sent; dropped unless allowed
   wire zeroDrop = frameInfo.isUdp & ~frameInfo.isUdpLite & frameInfo.udpChecksumZero
                   & ~zeroPass;
   wire icmpDrop = icmpCheck & frameInfo.isIcmp & ~frameInfo.isFragment
                   & frameInfo.icmpChecksumBad;
   wire sourceDrop = sourceFilter & (frameInfo.sourceAddress == stationAddress);
   wire tooLong = frameInfo.frameLength > TOO_LONG_LENGTH;
   wire longDrop = tooLong & ~badPass;
   wire dropNow = udpDrop | zeroDrop | icmpDrop | sourceDrop | longDrop;
   wire queueFull = frameCount == COUNT_WIDTH'(STATUS_DEPTH);
   wire pushStatus = frameEnd & ~dropNow & ~queueFull;
   wire overflow = frameEnd & ~dropNow & queueFull;

   // Destination class; first octet on the wire sits in the top byte
   wire isBroadcast = &frameInfo.destAddress;
   wire isMulticast = frameInfo.destAddress[40];
   wire typeIsEthertype = ~frameInfo.runt & (frameInfo.typeLength > ETHERTYPE_MIN_LENGTH);

   // Status word for the queue; valid bit is added on read
   logic [15:0] pushWord;
   always_comb begin
      pushWord = 16'h0000;
      pushWord[ICMP_BAD_BIT] = frameInfo.icmpChecksumBad;
      pushWord[IP_BAD_BIT] = frameInfo.ipHeaderChecksumBad;
      pushWord[TCP_BAD_BIT] = frameInfo.tcpChecksumBad;
      pushWord[UDP_BAD_BIT] = frameInfo.udpChecksumBad;
      pushWord[BROADCAST_BIT] = isBroadcast;
      pushWord[MULTICAST_BIT] = isMulticast;
      pushWord[UNICAST_BIT] = ~isMulticast;
      pushWord[SYMBOL_ERROR_BIT] = frameInfo.symbolError;
      pushWord[FRAME_TYPE_BIT] = typeIsEthertype;
      pushWord[TOO_LONG_BIT] = tooLong;
   end

   // Write channel: both halves held, then one register update
   wire doWrite = awFull & wFull & ~s_axi_bvalid;
   wire wrChecksum = doWrite & (awAddr == byteAddr(IDX_CHECKSUM_CONTROL));
   wire wrStationLow = doWrite & (awAddr == byteAddr(IDX_STATION_LOW));
   wire wrStationMid = doWrite & (awAddr == byteAddr(IDX_STATION_MID));
   wire wrStationHigh = doWrite & (awAddr == byteAddr(IDX_STATION_HIGH));
   wire wrOptions = doWrite & (awAddr == byteAddr(IDX_FILTER_OPTIONS));
   wire wrRelease = doWrite & (awAddr == byteAddr(IDX_FRAME_RELEASE));
   wire wrIntStatus = doWrite & (awAddr == byteAddr(IDX_INT_STATUS));
   wire wrIntMask = doWrite & (awAddr == byteAddr(IDX_INT_MASK));
   wire wrReadOnly = (awAddr == byteAddr(IDX_TRANSMIT_FREE))
                     | (awAddr == byteAddr(IDX_FRAME_STATUS))
                     | (awAddr == byteAddr(IDX_FRAME_COUNT));
   wire wrMapped = wrChecksum | wrStationLow | wrStationMid | wrStationHigh | wrOptions
                   | wrRelease | wrIntStatus | wrIntMask | (doWrite & wrReadOnly);
   wire [15:0] checksumMerged = mergeBytes({11'h000, checksumControl}, wData, wStrb);
   wire [15:0] optionsMerged = mergeBytes({14'h0000, filterOptions}, wData, wStrb);
   wire [15:0] maskMerged = mergeBytes({13'h0000, intMask}, wData, wStrb);

   // Releasing the head frame advances the status queue
   wire popStatus = wrRelease & wStrb[0] & wData[0] & (frameCount != '0);
   wire [EVENT_COUNT-1:0] intClear = (wrIntStatus & wStrb[0]) ? wData[EVENT_COUNT-1:0]
                                     : '0;
   wire [EVENT_COUNT-1:0] intSet = {overflow, frameEnd & dropNow, pushStatus};
   // Next mask too, so a mask write moves irq in the same cycle as the mask
   wire [EVENT_COUNT-1:0] next_intMask = wrIntMask ? maskMerged[EVENT_COUNT-1:0] : intMask;
   wire [EVENT_COUNT-1:0] next_intStatus = (intStatus & ~intClear) | intSet;

   // Read decode
   wire [15:0] headStatus = statusMem[readPtr[$clog2(STATUS_DEPTH)-1:0]];
   wire headValid = frameCount != '0;
   wire arTake = s_axi_arvalid & s_axi_arready;
   logic [31:0] readValue;
   logic readHit;
   always_comb begin
      readHit = 1'b1;
      readValue = 32'h00000000;
      if (s_axi_araddr == byteAddr(IDX_CHECKSUM_CONTROL)) begin
         readValue[4:0] = checksumControl;
      end else if (s_axi_araddr == byteAddr(IDX_TRANSMIT_FREE)) begin
         readValue[12:0] = transmitFree;
      end else if (s_axi_araddr == byteAddr(IDX_FRAME_STATUS)) begin
         readValue[15:0] = headValid ? (headStatus | 16'h8000) : 16'h0000;
      end else if (s_axi_araddr == byteAddr(IDX_STATION_LOW)) begin
         readValue[15:0] = stationAddress[15:0];
      end else if (s_axi_araddr == byteAddr(IDX_STATION_MID)) begin
         readValue[15:0] = stationAddress[31:16];
      end else if (s_axi_araddr == byteAddr(IDX_STATION_HIGH)) begin
         readValue[15:0] = stationAddress[47:32];
      end else if (s_axi_araddr == byteAddr(IDX_FILTER_OPTIONS)) begin
         readValue[1:0] = filterOptions;
      end else if (s_axi_araddr == byteAddr(IDX_FRAME_RELEASE)) begin
         readValue = 32'h00000000;
      end else if (s_axi_araddr == byteAddr(IDX_FRAME_COUNT)) begin
         readValue[COUNT_WIDTH-1:0] = frameCount;
      end else if (s_axi_araddr == byteAddr(IDX_INT_STATUS)) begin
         readValue[EVENT_COUNT-1:0] = intStatus;
      end else if (s_axi_araddr == byteAddr(IDX_INT_MASK)) begin
         readValue[EVENT_COUNT-1:0] = intMask;
      end else begin
         readHit = 1'b0;
      end
   end

   // Write address and data capture, in either order
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         awFull <= 1'b0;
         wFull <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         awAddr <= 12'h000;
         wData <= 32'h00000000;
         wStrb <= 4'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awFull <= 1'b1;
            s_axi_awready <= 1'b0;
            awAddr <= s_axi_awaddr;
         end else if (doWrite) begin
            awFull <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wFull <= 1'b1;
            s_axi_wready <= 1'b0;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end else if (doWrite) begin
            wFull <= 1'b0;
         end
         // Ready again only once the response is taken
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: one read in flight, data taken at the address edge
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (arTake) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readValue;
         s_axi_rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end

   // Software-written control registers
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         checksumControl <= CHECKSUM_CONTROL_RESET;
         filterOptions <= FILTER_OPTIONS_RESET;
         stationAddress <= 48'h000000000000;
         intMask <= '0;
      end else begin
         if (wrChecksum) begin
            checksumControl <= checksumMerged[4:0];
         end
         if (wrOptions) begin
            filterOptions <= optionsMerged[1:0];
         end
         if (wrStationLow) begin
            stationAddress[15:0] <= mergeBytes(stationAddress[15:0], wData, wStrb);
         end
         if (wrStationMid) begin
            stationAddress[31:16] <= mergeBytes(stationAddress[31:16], wData, wStrb);
         end
         if (wrStationHigh) begin
            stationAddress[47:32] <= mergeBytes(stationAddress[47:32], wData, wStrb);
         end
         if (wrIntMask) begin
            intMask <= maskMerged[EVENT_COUNT-1:0];
         end
      end
   end

   // Sticky events; a set in the clearing cycle survives the clear
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         intStatus <= '0;
         irq <= 1'b0;
      end else begin
         intStatus <= next_intStatus;
         irq <= |(next_intStatus & next_intMask);
      end
   end

   // Status queue pointers and occupancy
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         readPtr <= '0;
         writePtr <= '0;
         frameCount <= '0;
      end else begin
         if (pushStatus) begin
            writePtr <= (writePtr == COUNT_WIDTH'(STATUS_DEPTH - 1)) ? '0
                        : writePtr + 1'b1;
         end
         if (popStatus) begin
            readPtr <= (readPtr == COUNT_WIDTH'(STATUS_DEPTH - 1)) ? '0
                       : readPtr + 1'b1;
         end
         frameCount <= frameCount + COUNT_WIDTH'(pushStatus) - COUNT_WIDTH'(popStatus);
      end
   end

   // Status storage; no reset needed since occupancy guards every read
   always_ff @(posedge ref_clk) begin
      if (pushStatus) begin
         statusMem[writePtr[$clog2(STATUS_DEPTH)-1:0]] <= pushWord;
      end
   end

   // Frame decision pulses, free-space snapshot and transmit Lite control
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         frameAccept <= 1'b0;
         frameDrop <= 1'b0;
         transmitFree <= 13'h0000;
         txUdpLiteChecksumGen <= 1'b0;
      end else begin
         frameAccept <= pushStatus;
         frameDrop <= frameEnd & (dropNow | queueFull);
         transmitFree <= transmitFreeBytes;
         txUdpLiteChecksumGen <= liteEnable;
      end
   end

   // Checks on the filter decisions, the status queue, transmit Lite control and irq
   AST_SOURCE_DROP: assert property (@(posedge ref_clk) disable iff (!resetn)
      frameEnd && sourceFilter && (frameInfo.sourceAddress == stationAddress)
      |=> frameDrop && !frameAccept)
      else $error("frame from own station address was not dropped");
   AST_ZERO_DROP: assert property (@(posedge ref_clk) disable iff (!resetn)
      frameEnd && frameInfo.isUdp && !frameInfo.isUdpLite && frameInfo.udpChecksumZero
      && !zeroPass |=> frameDrop)
      else $error("zero checksum UDP frame passed while not allowed");
   AST_ICMP_DROP: assert property (@(posedge ref_clk) disable iff (!resetn)
      frameEnd && icmpCheck && frameInfo.isIcmp && !frameInfo.isFragment
      && frameInfo.icmpChecksumBad |=> frameDrop && !frameAccept)
      else $error("bad ICMP frame was accepted");
   AST_LONG_DROP: assert property (@(posedge ref_clk) disable iff (!resetn)
      frameEnd && (frameInfo.frameLength > TOO_LONG_LENGTH) && !badPass |=> frameDrop)
      else $error("over-length frame accepted without bad-frame pass");
   AST_FRAGMENT_PASS: assert property (@(posedge ref_clk) disable iff (!resetn)
      frameEnd && frameInfo.isFragment && fragmentPass && !zeroDrop && !icmpDrop
      && !sourceDrop && !longDrop && !queueFull |=> frameAccept && !frameDrop)
      else $error("fragment frame failed UDP check with fragment pass set");
   AST_LITE_TX: assert property (@(posedge ref_clk) disable iff (!resetn)
      wrChecksum ##1 1'b1 |=> txUdpLiteChecksumGen == checksumControl[LITE_ENABLE_BIT])
      else $error("transmit Lite checksum control does not follow register");
   AST_POP_ADVANCE: assert property (@(posedge ref_clk) disable iff (!resetn)
      popStatus && !pushStatus |=> frameCount == $past(frameCount) - 1'b1)
      else $error("frame release did not advance status queue");
   AST_EMPTY_INVALID: assert property (@(posedge ref_clk) disable iff (!resetn)
      arTake && (s_axi_araddr == byteAddr(IDX_FRAME_STATUS)) && (frameCount == '0)
      |=> s_axi_rvalid && !s_axi_rdata[VALID_BIT])
      else $error("frame valid read high with empty queue");
   AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!resetn)
      irq == |(intStatus & intMask))
      else $error("interrupt not raised for unmasked event");

endmodule : rx_checksum_filter_status

// file: verification/frame_source.sv
/* Receive datapath and transmit queue model feeding the block.
   Assumes the bench calls send() from its clocked sequence. */
`timescale 1ns/10ps
module frame_source
   import rx_filter_pkg::*;
(
   // Clock
   input wire logic clk,
   // Frame descriptor and free space
   output logic frameEnd,
   output frame_info_type frameInfo,
   output logic [12:0] transmitFreeBytes
);
   // One-cycle descriptor; bus shows junk after, never the old value
   task automatic send(input frame_info_type fi);
      @(posedge clk);
      frameEnd <= 1'b1;
      frameInfo <= fi;
      @(posedge clk);
      frameEnd <= 1'b0;
      frameInfo <= ~fi;
   endtask : send
   // Idle values
   initial begin
      frameEnd = 1'b0;
      frameInfo = '0;
      transmitFreeBytes = 13'h1abc;
   end
endmodule : frame_source

// file: verification/testbench.sv
/* Self-checking bench: AXI4-Lite master tasks, one task per scenario.
   Assumes the block and frame_source share ref_clk. */
`timescale 1ns/10ps
module testbench;
   import rx_filter_pkg::*;
   logic ref_clk, resetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic bvalid, arready, rvalid, frameEnd, frameAccept, frameDrop, txGen, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, resp;
   logic [12:0] freeBytes;
   frame_info_type frameInfo, f;
   int miscompares = 0;
   int nChecks = 0;
   rx_checksum_filter_status dut (.ref_clk(ref_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .frameEnd(frameEnd), .frameInfo(frameInfo), .frameAccept(frameAccept),
      .frameDrop(frameDrop), .transmitFreeBytes(freeBytes), .txUdpLiteChecksumGen(txGen),
      .irq(irq));
   frame_source src (.clk(ref_clk), .frameEnd(frameEnd), .frameInfo(frameInfo),
      .transmitFreeBytes(freeBytes));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Bus master: hold each channel until its own ready
   task automatic wr(input logic [7:0] idx, input logic [15:0] v);
      int n;
      @(posedge ref_clk);
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= {16'h0000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      resp = bresp;
      bready <= 1'b0;
      if (n == 50) begin
         miscompares++;
         end_sim();
      end
   endtask : wr
   task automatic rd(input logic [7:0] idx, output logic [31:0] v);
      int n;
      @(posedge ref_clk);
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n == 50) begin
         miscompares++;
         end_sim();
      end
   endtask : rd
   function automatic frame_info_type base();
      base = '0;
      base.sourceAddress = 48'h020000000099;
      base.destAddress = 48'h020000000001;
      base.typeLength = 16'h0800;
      base.frameLength = 16'h0040;
   endfunction : base
   // Send, judge the verdict, then for an accepted frame read and release the head status
   task automatic frm(input frame_info_type x, input logic acc);
      logic [15:0] s;
      s = {2'b10, x.icmpChecksumBad, x.ipHeaderChecksumBad, x.tcpChecksumBad,
         x.udpChecksumBad, 2'b00, &x.destAddress, x.destAddress[40], !x.destAddress[40],
         x.symbolError, !x.runt && x.typeLength > ETHERTYPE_MIN_LENGTH,
         x.frameLength > TOO_LONG_LENGTH, 2'b00};
      src.send(x);
      #1;
      chk("accept", 32'(acc), 32'(frameAccept));
      chk("drop", 32'(!acc), 32'(frameDrop));
      if (acc) begin
         rd(IDX_FRAME_COUNT, d);
         chk("count", 32'h1, d);
         rd(IDX_FRAME_STATUS, d);
         chk("status", {16'h0000, s}, d & 32'hfffffffc);
         wr(IDX_FRAME_RELEASE, 16'h0001);
         rd(IDX_FRAME_STATUS, d);
         chk("valid", 32'h0, 32'(d[15]));
      end
   endtask : frm
   task automatic t_regs();
      rd(IDX_CHECKSUM_CONTROL, d);
      chk("control", 32'h4, d);
      chk("txgen", 32'h1, 32'(txGen));
      rd(IDX_TRANSMIT_FREE, d);
      chk("free", 32'h1abc, d);
      wr(IDX_TRANSMIT_FREE, 16'h0000);
      rd(IDX_TRANSMIT_FREE, d);
      chk("free ro", 32'h1abc, d);
      wr(8'h50, 16'h0001);
      chk("bresp", 32'h2, 32'(resp));
      rd(8'h50, d);
      chk("rresp", 32'h2, 32'(resp));
      chk("unmapped", 32'h0, d);
      $display("test regs done");
   endtask : t_regs
   // Flags, type boundary at 1500, length boundary at 2000
   task automatic t_status();
      f = base();
      f.destAddress = '1;
      {f.symbolError, f.icmpChecksumBad, f.ipHeaderChecksumBad} = 3'h7;
      {f.tcpChecksumBad, f.udpChecksumBad} = 2'h3;
      f.typeLength = 16'd1501;
      frm(f, 1'b1);
      f = base();
      f.destAddress = 48'h010000000001;
      f.typeLength = 16'd1500;
      f.frameLength = 16'd2000;
      frm(f, 1'b1);
      f.frameLength = 16'd2001;
      frm(f, 1'b0);
      wr(IDX_FILTER_OPTIONS, 16'h0001);
      frm(f, 1'b1);
      $display("test status done");
   endtask : t_status
   // Zero checksum, fragment pass and Lite enable
   task automatic t_udp();
      f = base();
      {f.isUdp, f.udpChecksumZero} = 2'h3;
      frm(f, 1'b0);
      wr(IDX_CHECKSUM_CONTROL, 16'h000c);
      frm(f, 1'b1);
      wr(IDX_FILTER_OPTIONS, 16'h0002);
      f = base();
      {f.isUdp, f.udpChecksumBad, f.isFragment} = 3'h7;
      frm(f, 1'b0);
      wr(IDX_CHECKSUM_CONTROL, 16'h0014);
      frm(f, 1'b1);
      f = base();
      {f.isUdp, f.isUdpLite, f.udpChecksumBad} = 3'h7;
      frm(f, 1'b0);
      wr(IDX_CHECKSUM_CONTROL, 16'h0010);
      frm(f, 1'b1);
      chk("txgen off", 32'h0, 32'(txGen));
      $display("test udp done");
   endtask : t_udp
   // ICMP check and own-source filter, then interrupt masking
   task automatic t_misc();
      wr(IDX_CHECKSUM_CONTROL, 16'h0002);
      f = base();
      {f.isIcmp, f.icmpChecksumBad} = 2'h3;
      frm(f, 1'b0);
      f.isFragment = 1'b1;
      frm(f, 1'b1);
      wr(IDX_STATION_LOW, 16'h0099);
      wr(IDX_STATION_MID, 16'h0000);
      wr(IDX_STATION_HIGH, 16'h0200);
      wr(IDX_CHECKSUM_CONTROL, 16'h0001);
      frm(base(), 1'b0);
      wr(IDX_INT_STATUS, 16'h0007);
      wr(IDX_INT_MASK, 16'h0001);
      f = base();
      f.sourceAddress = 48'h020000000098;
      frm(f, 1'b1);
      chk("irq", 32'h1, 32'(irq));
      wr(IDX_INT_STATUS, 16'h0001);
      @(posedge ref_clk);
      #1;
      chk("irq clear", 32'h0, 32'(irq));
      $display("test misc done");
   endtask : t_misc
   initial begin
      {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs();
      t_status();
      t_udp();
      t_misc();
      end_sim();
   end
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
endmodule : testbench
